// [src/acs_params.svh]
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// *****************************************************************
// register offsets on the plain register port
// *****************************************************************
`define ACS_ADDR_W          3
`define ACS_OFF_CTRL_A      3'h0
`define ACS_OFF_CTRL_B      3'h1
`define ACS_OFF_INSEL       3'h2
`define ACS_OFF_RES_LO      3'h3
`define ACS_OFF_RES_HI      3'h4

// *****************************************************************
// field positions
// *****************************************************************
`define ACS_CA_ENABLE       7
`define ACS_CA_START        6
`define ACS_CA_AUTO         5
`define ACS_CA_DONE         4
`define ACS_CA_PS_MSB       2
`define ACS_CB_TS_MSB       2
`define ACS_IS_REF_MSB      7
`define ACS_IS_REF_LSB      6
`define ACS_IS_CH_MSB       4

// *****************************************************************
// reset values
// *****************************************************************
`define ACS_RST_BYTE        8'h00
`define ACS_RST_RESULT      10'h000

// *****************************************************************
// timing in half adc clock cycles, trigger sync in cpu clocks
// *****************************************************************
`define ACS_HC_W            6
`define ACS_LEN_NORMAL      6'h1a
`define ACS_LEN_DIFF_HI     6'h1c
`define ACS_LEN_AUTO        6'h1b
`define ACS_LEN_FIRST       6'h32
`define ACS_SMP_NORMAL      6'h03
`define ACS_SMP_DIFF_HI     6'h05
`define ACS_SMP_AUTO        6'h04
`define ACS_SMP_FIRST       6'h1b
`define ACS_LAST_CYC_HALVES 6'h02
`define ACS_TRIG_SYNC_CYC   2'h3

// *****************************************************************
// prescaler
// *****************************************************************
`define ACS_PRE_W           8

`endif

// [src/acs_pkg.sv]
`include "acs_params.svh"

package acs_pkg;

    // conversion sequencer states
    typedef enum logic [1:0] {ACS_IDLE, ACS_PEND, ACS_SYNC, ACS_CONV} acs_state_t;

    // prescaler state
    typedef struct packed {
        logic [`ACS_PRE_W-1:0] cnt;
        logic                  rise;
        logic                  mid;
        logic                  half;
    } acs_pre_t;

    // sequencer state
    typedef struct packed {
        acs_state_t           state;
        logic                 en;
        logic                 ate;
        logic                 done;
        logic [2:0]           ps;
        logic [2:0]           tsel;
        logic [4:0]           sel_ch;
        logic [1:0]           sel_ref;
        logic [4:0]           app_ch;
        logic [1:0]           app_ref;
        logic                 locked;
        logic                 first;
        logic [`ACS_HC_W-1:0] hcnt;
        logic [`ACS_HC_W-1:0] len;
        logic [`ACS_HC_W-1:0] samp;
        logic [1:0]           sync;
        logic                 trig_q;
        logic                 pre_restart;
        logic [9:0]           result;
        logic                 blocked;
        logic [7:0]           rdata;
        logic                 sample;
        logic                 done_pulse;
        logic                 busy;
    } acs_seq_t;

endpackage : acs_pkg

// [src/acs_prescaler.sv]
`timescale 1ns/100ps
`include "acs_params.svh"

module acs_prescaler (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // control
    input  wire logic                  run,
    input  wire logic                  restart,
    input  wire logic [`ACS_PRE_W-1:0] ratio,
    // adc clock events
    output logic                       rise_ff,
    output logic                       mid_ff,
    output logic                       half_clk_ff
);

    acs_pkg::acs_pre_t s_ff;
    acs_pkg::acs_pre_t nxt_s;

    // *************************************************************
    // divider: rise at end of period, mid halfway through
    // *************************************************************
    // ratio must be 2 or more, else mid is lost or collides with rise
    always_comb
    begin
        nxt_s      = s_ff;
        nxt_s.rise = 1'b0;
        nxt_s.mid  = 1'b0;
        if (!run || restart)
        begin
            nxt_s.cnt  = '0;
            nxt_s.half = 1'b0;
        end
        else
        begin
            // greater-or-equal: a ratio cut mid count must not wrap round
            nxt_s.rise = (s_ff.cnt >= ratio - `ACS_PRE_W'(1));
            nxt_s.mid  = (s_ff.cnt == (ratio >> 1) - `ACS_PRE_W'(1));
            if (nxt_s.rise)
            begin
                nxt_s.cnt  = '0;
                nxt_s.half = ~s_ff.half;   // half rate sync clock
            end
            else
            begin
                nxt_s.cnt = s_ff.cnt + `ACS_PRE_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign rise_ff     = s_ff.rise;
    assign mid_ff      = s_ff.mid;
    assign half_clk_ff = s_ff.half;

endmodule : acs_prescaler

// [src/acs_sequencer.sv]
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "acs_params.svh"

// Functional notes
// - writing start bit launches one conversion; bit stays set until it ends
// - channel change mid conversion applies only from its last adc cycle
// - trigger rising edge with auto trigger resets prescaler and starts conversion
// - held trigger level or edges during conversion start nothing
// - trigger source flag must be cleared before its next event triggers
// - completion flag as source restarts after each conversion, flag cleared or not
// - start bit works with auto trigger too and reads one while busy
// - prescale select picks ratio; prescaler runs only while enabled
// - software start begins on next rising adc clock edge
// - normal conversion 13 adc clocks, first after enable 25
// - sample at 1.5 clocks, first conversion at 13.5
// - completion stores result, sets done flag, clears start bit together
// - auto triggered sample 2 clocks after edge, 3 cpu clocks sync, 13.5 total
// - differential with non-done auto trigger always takes 25 clocks
// - free running restarts at once, start bit stays set
// - differential user start 13 clocks if half clock low, 14 if high
// - free running differential restarts take 14 clocks
// - low byte read blocks result updates until high byte read
// - selection buffer tracks, locks at start, unlocks in last adc cycle
module acs_sequencer #(
    parameter int                         NTRIG          = 8,
    parameter logic [2:0]                 TRIG_DONE_SEL  = 3'h0,
    parameter logic [4:0]                 DIFF_FIRST_CH  = 5'h08,
    parameter logic [7:0][`ACS_PRE_W-1:0] PRESCALE_RATIO =
        {8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h02}
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // register port
    input  wire logic [`ACS_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    // trigger sources and converter core
    input  wire logic [NTRIG-1:0]       trigger_in,
    input  wire logic [9:0]             result_in,
    // analog side controls
    output logic                        converter_on,
    output logic                        first_conv,
    output logic                        conv_busy,
    output logic                        sample_strobe,
    output logic                        conv_done_pulse,
    output logic                        conversion_done_flag,
    output logic      [4:0]             applied_channel,
    output logic      [1:0]             applied_reference
);

    acs_pkg::acs_seq_t s_ff;
    acs_pkg::acs_seq_t nxt_s;

    logic                   pre_rise;
    logic                   pre_mid;
    logic                   half_rate_sync_clock;
    logic                   trig_lvl;
    logic                   trig_edge;
    logic                   half_ev;
    logic                   auto_done;
    logic                   start_req;
    logic [`ACS_HC_W-1:0]   hnext;

    // *************************************************************
    // helpers
    // *************************************************************
    // differential channels sit above the single ended block
    function automatic logic is_diff(input logic [4:0] ch);
        is_diff = (ch >= DIFF_FIRST_CH);
    endfunction : is_diff

    // *************************************************************
    // adc clock prescaler
    // *************************************************************
    acs_prescaler u_pre (
        .clk         (clk),
        .reset_n     (reset_n),
        .run         (s_ff.en),
        .restart     (s_ff.pre_restart),
        .ratio       (PRESCALE_RATIO[s_ff.ps]),
        .rise_ff     (pre_rise),
        .mid_ff      (pre_mid),
        .half_clk_ff (half_rate_sync_clock)
    );

    // trigger pick and edge test
    assign trig_lvl  = trigger_in[s_ff.tsel];
    assign trig_edge = trig_lvl & ~s_ff.trig_q;
    assign auto_done = s_ff.ate && (s_ff.tsel == TRIG_DONE_SEL);
    assign half_ev   = pre_rise | pre_mid;
    assign hnext     = s_ff.hcnt + `ACS_HC_W'(1);
    // only honoured in idle with the converter on, ignored elsewhere
    assign start_req = reg_wr && (reg_addr == `ACS_OFF_CTRL_A)
                       && reg_wdata[`ACS_CA_START];

    // *************************************************************
    // next state
    // *************************************************************
    always_comb
    begin
        nxt_s             = s_ff;
        nxt_s.sample      = 1'b0;
        nxt_s.done_pulse  = 1'b0;
        nxt_s.pre_restart = 1'b0;
        nxt_s.trig_q      = trig_lvl;

        // register writes; the done flag clears by writing one
        if (reg_wr)
        begin
            case (reg_addr)
                `ACS_OFF_CTRL_A:
                begin
                    nxt_s.en  = reg_wdata[`ACS_CA_ENABLE];
                    nxt_s.ate = reg_wdata[`ACS_CA_AUTO];
                    nxt_s.ps  = reg_wdata[`ACS_CA_PS_MSB:0];
                    if (reg_wdata[`ACS_CA_DONE])
                        nxt_s.done = 1'b0;
                end
                `ACS_OFF_CTRL_B:
                    nxt_s.tsel = reg_wdata[`ACS_CB_TS_MSB:0];
                `ACS_OFF_INSEL:
                begin
                    nxt_s.sel_ch  = reg_wdata[`ACS_IS_CH_MSB:0];
                    nxt_s.sel_ref = reg_wdata[`ACS_IS_REF_MSB:`ACS_IS_REF_LSB];
                end
                default:
                    nxt_s.en = s_ff.en;
            endcase
        end

        // reads answer one cycle later; reading bytes steers the block
        nxt_s.rdata = `ACS_RST_BYTE;
        if (reg_rd)
        begin
            case (reg_addr)
                `ACS_OFF_CTRL_A:
                    nxt_s.rdata = {s_ff.en, s_ff.busy,
                                   s_ff.ate, s_ff.done, 1'b0, s_ff.ps};
                `ACS_OFF_CTRL_B:
                    nxt_s.rdata = {5'h00, s_ff.tsel};
                `ACS_OFF_INSEL:
                    nxt_s.rdata = {s_ff.sel_ref, 1'b0, s_ff.sel_ch};
                `ACS_OFF_RES_LO:
                begin
                    nxt_s.rdata   = s_ff.result[7:0];
                    nxt_s.blocked = 1'b1;
                end
                `ACS_OFF_RES_HI:
                begin
                    nxt_s.rdata   = {6'h00, s_ff.result[9:8]};
                    nxt_s.blocked = 1'b0;
                end
                default:
                    nxt_s.rdata = `ACS_RST_BYTE;
            endcase
        end

        // selection buffer follows the written value while unlocked
        if (!s_ff.locked)
        begin
            nxt_s.app_ch  = s_ff.sel_ch;
            nxt_s.app_ref = s_ff.sel_ref;
        end

        // sequencer
        if (!s_ff.en)
        begin
            // disabled: abort, unlock, next conversion is a long one
            nxt_s.state  = acs_pkg::ACS_IDLE;
            nxt_s.locked = 1'b0;
            nxt_s.first  = 1'b1;
            nxt_s.hcnt   = '0;
        end
        else
        begin
            case (s_ff.state)
                acs_pkg::ACS_IDLE:
                begin
                    // software start has priority over a coincident edge
                    if (start_req)
                        nxt_s.state = acs_pkg::ACS_PEND;
                    else if (s_ff.ate && !auto_done && trig_edge)
                    begin
                        nxt_s.state  = acs_pkg::ACS_SYNC;
                        nxt_s.sync   = 2'h0;
                        nxt_s.locked = 1'b1;
                    end
                end
                acs_pkg::ACS_PEND:
                begin
                    // begins on the next rising adc clock edge
                    if (pre_rise)
                    begin
                        nxt_s.state  = acs_pkg::ACS_CONV;
                        nxt_s.hcnt   = '0;
                        nxt_s.locked = 1'b1;
                        nxt_s.first  = 1'b0;
                        if (s_ff.first)
                        begin
                            nxt_s.len  = `ACS_LEN_FIRST;
                            nxt_s.samp = `ACS_SMP_FIRST;
                        end
                        else if (is_diff(s_ff.app_ch) && half_rate_sync_clock)
                        begin
                            nxt_s.len  = `ACS_LEN_DIFF_HI;
                            nxt_s.samp = `ACS_SMP_DIFF_HI;
                        end
                        else
                        begin
                            nxt_s.len  = `ACS_LEN_NORMAL;
                            nxt_s.samp = `ACS_SMP_NORMAL;
                        end
                    end
                end
                acs_pkg::ACS_SYNC:
                begin
                    // cpu clocks of synchronisation, then prescaler restart
                    nxt_s.sync = s_ff.sync + 2'h1;
                    if (s_ff.sync == `ACS_TRIG_SYNC_CYC - 2'h1)
                    begin
                        nxt_s.pre_restart = 1'b1;
                        nxt_s.state       = acs_pkg::ACS_CONV;
                        nxt_s.hcnt        = '0;
                        nxt_s.first       = 1'b0;
                        // gain stage needs a steady clock, so use the long form
                        if (s_ff.first || is_diff(s_ff.app_ch))
                        begin
                            nxt_s.len  = `ACS_LEN_FIRST;
                            nxt_s.samp = `ACS_SMP_FIRST;
                        end
                        else
                        begin
                            nxt_s.len  = `ACS_LEN_AUTO;
                            nxt_s.samp = `ACS_SMP_AUTO;
                        end
                    end
                end
                acs_pkg::ACS_CONV:
                begin
                    if (half_ev)
                    begin
                        nxt_s.hcnt = hnext;
                        if (hnext == s_ff.samp)
                            nxt_s.sample = 1'b1;
                        // reopen the buffer for the final adc cycle
                        if (hnext >= s_ff.len - `ACS_LAST_CYC_HALVES)
                            nxt_s.locked = 1'b0;
                        if (hnext == s_ff.len)
                        begin
                            nxt_s.done       = 1'b1;
                            nxt_s.done_pulse = 1'b1;
                            // a low byte read in this same cycle already blocks
                            if (!nxt_s.blocked)
                                nxt_s.result = result_in;
                            if (auto_done)
                            begin
                                // restart regardless of the flag state
                                nxt_s.hcnt   = '0;
                                nxt_s.locked = 1'b1;
                                if (is_diff(s_ff.app_ch))
                                begin
                                    nxt_s.len  = `ACS_LEN_DIFF_HI;
                                    nxt_s.samp = `ACS_SMP_DIFF_HI;
                                end
                                else
                                begin
                                    nxt_s.len  = `ACS_LEN_NORMAL;
                                    nxt_s.samp = `ACS_SMP_NORMAL;
                                end
                            end
                            else
                            begin
                                nxt_s.state = acs_pkg::ACS_IDLE;
                            end
                        end
                    end
                end
                default:
                    nxt_s.state = acs_pkg::ACS_IDLE;
            endcase
        end

        // start bit readback taken from the next state, so the pin
        // is a plain flip-flop and shows no decode glitch
        nxt_s.busy = (nxt_s.state != acs_pkg::ACS_IDLE);
    end

    // *************************************************************
    // state register
    // *************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // reset leaves the next conversion marked as the long first one
            s_ff        <= '0;
            s_ff.state  <= acs_pkg::ACS_IDLE;
            s_ff.first  <= 1'b1;
            s_ff.result <= `ACS_RST_RESULT;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign reg_rdata            = s_ff.rdata;
    assign converter_on         = s_ff.en;
    assign first_conv           = s_ff.first;
    assign conv_busy            = s_ff.busy;
    assign sample_strobe        = s_ff.sample;
    assign conv_done_pulse      = s_ff.done_pulse;
    assign conversion_done_flag = s_ff.done;
    assign applied_channel      = s_ff.app_ch;
    assign applied_reference    = s_ff.app_ref;

endmodule : acs_sequencer

// [sim/acs_core_model.sv]
`timescale 1ns/100ps

// *****************************************************************
// converter core model: takes a new code at each sample strobe
// *****************************************************************
module acs_core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // sequencer side
    input  wire logic       sample_strobe,
    output logic      [9:0] result_in
);
    logic [9:0] lfsr_ff;

    // pattern moves every cycle, so a late or early sample shows up
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lfsr_ff   <= 10'h001;
            result_in <= 10'h2aa;
        end
        else
        begin
            lfsr_ff <= {lfsr_ff[8:0], lfsr_ff[9] ^ lfsr_ff[6]};
            if (sample_strobe)
                result_in <= lfsr_ff;  // held until next sample, like a s/h
        end
    end
endmodule : acs_core_model

// [sim/acs_sequencer_monitor.sv]
`timescale 1ns/100ps

// *****************************************************************
// port checker for the sequencer
// *****************************************************************
module acs_sequencer_monitor #(
    parameter int NTRIG = 8
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             reset_n,
    // register port
    input wire logic [2:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    // trigger and core
    input wire logic [NTRIG-1:0] trigger_in,
    input wire logic [9:0]       result_in,
    // analog side
    input wire logic             converter_on,
    input wire logic             first_conv,
    input wire logic             conv_busy,
    input wire logic             sample_strobe,
    input wire logic             conv_done_pulse,
    input wire logic             conversion_done_flag,
    input wire logic [4:0]       applied_channel,
    input wire logic [1:0]       applied_reference
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic rd_q_ff;

    // read strobe one cycle late frames the read data
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            rd_q_ff <= 1'b0;
        else
            rd_q_ff <= reg_rd;

    AST_RDATA_IDLE: assert property (!rd_q_ff |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_DONE_FLAG: assert property (conv_done_pulse |-> conversion_done_flag)
        else $error("done flag missing at completion");
    AST_DONE_PULSE: assert property (conv_done_pulse |=> !conv_done_pulse)
        else $error("completion pulse too long");
    AST_BUSY_END: assert property ($fell(conv_busy) |-> conv_done_pulse || !converter_on)
        else $error("busy dropped without completion");
    AST_SAMPLE_BUSY: assert property (sample_strobe |-> conv_busy && converter_on)
        else $error("sample outside conversion");
    AST_SAMPLE_LOCK: assert property (sample_strobe |->
        $stable(applied_channel) && $stable(applied_reference))
        else $error("selection moved at sample");
    AST_OFF_IDLE: assert property (!converter_on && !reg_wr |=> !conv_busy)
        else $error("busy while disabled");
    AST_OFF_FIRST: assert property (!converter_on [*2] |-> first_conv)
        else $error("first flag lost while disabled");
    AST_MIN_LEN: assert property (conv_done_pulse |-> $past(conv_busy, 20))
        else $error("conversion too short");

    COV_FREE: cover property (conv_done_pulse && conv_busy);
    COV_SAMPLE: cover property (sample_strobe ##[1:60] conv_done_pulse);
    COV_OFF: cover property ($fell(converter_on));
endmodule : acs_sequencer_monitor

bind acs_sequencer acs_sequencer_monitor #(.NTRIG(NTRIG)) acs_sequencer_monitor_i (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .trigger_in, .result_in, .converter_on, .first_conv, .conv_busy, .sample_strobe,
    .conv_done_pulse, .conversion_done_flag, .applied_channel, .applied_reference
);

// [sim/acs_sequencer_test.sv]
`timescale 1ns/100ps

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

// *****************************************************************
// testbench for the conversion sequencer
// *****************************************************************
module acs_sequencer_test;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] trigger_in = 8'h00;
    logic [7:0] reg_rdata, d;
    logic [9:0] result_in, exp_res;
    logic [4:0] applied_channel, ch, pch;
    logic [1:0] applied_reference;
    logic       converter_on, first_conv, conv_busy, sample_strobe, conv_done_pulse, done_flag;
    int         failures = 0, checked = 0, seed = 65531, n, k, sel;

    always #25 clk = ~clk;

    acs_sequencer acs_sequencer_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trigger_in(trigger_in), .result_in(result_in), .converter_on(converter_on),
        .first_conv(first_conv), .conv_busy(conv_busy), .sample_strobe(sample_strobe),
        .conv_done_pulse(conv_done_pulse), .conversion_done_flag(done_flag),
        .applied_channel(applied_channel), .applied_reference(applied_reference));
    acs_core_model acs_core_model_i (.clk(clk), .reset_n(reset_n),
        .sample_strobe(sample_strobe), .result_in(result_in));

    // cycles per conversion at ratio 2, where half an adc clock is one cpu clock
    function automatic int conv_len(input logic first_c);
        return first_c ? 50 : 26;
    endfunction : conv_len

    task automatic final_report;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // bounded so a dead sequencer cannot hang the run
    task automatic wait_done(output int c);
        c = 0;
        do
        begin
            @(posedge clk);
            #1 c++;
        end
        while (conv_done_pulse !== 1'b1 && c < 3000);
        if (c >= 3000)
        begin
            failures++;
            final_report;
        end
    endtask : wait_done

    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        wr(3'h5, 8'hff);
        for (k = 0; k < 6; k++)
        begin
            rd(k[2:0], d);
            `CHK(d, 8'h00)
        end
        `CHK(first_conv, 1'b1)
        $display("test reset done");
        wr(3'h2, 8'h05);
        wr(3'h0, 8'h80);
        wr(3'h0, 8'hc0);
        wait_done(n);
        `CHK((n >= conv_len(1'b1)) && (n <= conv_len(1'b1) + 4), 1'b1)
        `CHK({done_flag, conv_busy}, 2'b10)
        // random channels, mid-run channel change and result readback
        pch = 5'h05;
        for (k = 0; k < 5; k++)
        begin
            ch = pch ^ 5'(1 + {$random(seed)} % 7);
            wr(3'h0, 8'hc0);
            rd(3'h0, d);
            `CHK(d[6], 1'b1)
            wr(3'h2, {k[1:0], 1'b0, ch});
            `CHK(applied_channel, pch)
            wait_done(n);
            `CHK((n + 4 >= conv_len(1'b0)) && (n <= conv_len(1'b0)), 1'b1)
            `CHK(applied_channel, ch)
            `CHK(applied_reference, k[1:0])
            pch = ch;
            exp_res = result_in;
            rd(3'h3, d);
            `CHK(d, exp_res[7:0])
            rd(3'h4, d);
            `CHK(d, {6'h00, exp_res[9:8]})
        end
        $display("test single done");
        rd(3'h3, d);
        wr(3'h0, 8'h90);
        @(negedge clk);
        `CHK(done_flag, 1'b0)
        wr(3'h0, 8'hc0);
        wait_done(n);
        `CHK(done_flag, 1'b1)
        rd(3'h4, d);
        `CHK(d, {6'h00, exp_res[9:8]})
        rd(3'h3, d);
        `CHK(d, exp_res[7:0])
        // slowest ratio, inside the full resolution band: 64 cycles a half clock
        wr(3'h0, 8'hc7);
        wait_done(n);
        `CHK((n > 64 * conv_len(1'b0)) && (n <= 64 * conv_len(1'b0) + 128), 1'b1)
        $display("test blocking done");
        sel = 1 + ({$random(seed)} % 7);
        wr(3'h2, 8'h08);
        wr(3'h1, 8'(sel));
        wr(3'h0, 8'ha0);
        k = 0;
        for (n = 0; n < 300; n++)
        begin
            @(posedge clk);
            trigger_in[sel] <= !(n == 10 || (n >= 100 && n < 105));
            // differential channel: enable off and on between the triggers
            reg_wdata <= (n == 60) ? 8'h20 : 8'ha0;
            reg_wr    <= (n == 60 || n == 62);
            #1 k += int'(conv_done_pulse);
        end
        `CHK(k, 2)
        $display("test trigger done");
        wr(3'h1, 8'h00);
        wr(3'h0, 8'he0);
        wait_done(n);
        wait_done(n);
        `CHK(n, conv_len(1'b0) + 2)
        `CHK(conv_busy, 1'b1)
        $display("test free run done");
        wr(3'h0, 8'h00);
        wr(3'h0, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        `CHK({conv_busy, first_conv, converter_on}, 3'b010)
        $display("test disable done");
        final_report;
    end
endmodule : acs_sequencer_test
